// *** sasl_pkg.sv ***
// sasl_pkg: constants, register map and carrier types of the secure access
// status logic. assumes a 32-bit register port with 12-bit byte addresses.
package sasl_pkg;

    // register port geometry
    localparam int          SASL_ADDR_W        = 12;
    localparam int          SASL_DATA_W        = 32;
    localparam int          SASL_SEL_W         = 6;
    localparam int          SASL_MAX_CH        = 64;

    // register byte offsets
    localparam logic [11:0] SASL_OFF_CTRL      = 12'h000;
    localparam logic [11:0] SASL_OFF_UNLOCK    = 12'h004;
    localparam logic [11:0] SASL_OFF_CLEAR     = 12'h008;
    localparam logic [11:0] SASL_OFF_STATUS    = 12'h010;
    localparam logic [11:0] SASL_OFF_REMAP     = 12'h100;

    // control register fields
    localparam int          SASL_CTRL_EN_BIT    = 0;
    localparam int          SASL_CTRL_SETUP_BIT = 1;

    // status register fields
    localparam int          SASL_ST_IDLE_BIT   = 10;
    localparam int          SASL_ST_SETUP_BIT  = 9;
    localparam int          SASL_ST_EN_BIT     = 8;
    localparam int          SASL_ST_ERR_LSB    = 3;
    localparam int          SASL_ERR_W         = 5;
    localparam logic [31:0] SASL_STATUS_RESET  = 32'h0000_0400;

    // index of each flag inside the error vector (status bits 7..3)
    localparam int          SASL_E_UNL_READ    = 0;
    localparam int          SASL_E_UNL_KEY     = 1;
    localparam int          SASL_E_UNL_BLOCK   = 2;
    localparam int          SASL_E_MBERR       = 3;
    localparam int          SASL_E_REMAP       = 4;

    // unlock register layout: key in the top byte, channel in the low bits
    localparam int          SASL_KEY_LSB       = 24;
    localparam logic [7:0]  SASL_UNLOCK_KEY    = 8'ha5;

    // legal remap targets have an upper half of 0xfffc..0xffff
    localparam logic [15:0] SASL_REMAP_MIN     = 16'hfffc;

    // channel engine states, gray coded along the usual path
    typedef enum logic [1:0] {
        SASL_S_IDLE  = 2'b00,
        SASL_S_ISSUE = 2'b01,
        SASL_S_WAIT  = 2'b11,
        SASL_S_DONE  = 2'b10
    } sasl_fsm_e;

    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic [SASL_SEL_W-1:0] sel;
        logic [31:0]           wdata;
    } sasl_ch_req_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sasl_mst_req_s;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [31:0] rdata;
    } sasl_mst_rsp_s;

endpackage

// *** sasl_top.sv ***
// sasl_top: status, error flags and channel forwarding of the secure access unit.
// assumes a single clock, synchronous inputs and a master side that answers
// each accepted transfer with exactly one response, never in the accept cycle.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps

module sasl_top
    import sasl_pkg::*;
#(
    parameter int NUM_CH = 64
) (
    input  wire logic                            clk,
    input  wire logic                            nrst,
    input  wire logic                            ce,
    input  wire logic [sasl_pkg::SASL_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                     reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [31:0]                     reg_rdata,
    input  wire sasl_pkg::sasl_ch_req_s          ch_req,
    output logic                                 ch_ready,
    output logic                                 ch_ack,
    output logic                                 ch_err,
    output logic      [31:0]                     ch_rdata,
    output sasl_pkg::sasl_mst_req_s              m_req,
    input  wire logic                            m_ready,
    input  wire sasl_pkg::sasl_mst_rsp_s         m_rsp,
    output logic                                 enabled,
    output logic                                 setup_mode_flag
);
    import sasl_pkg::*;

    if (NUM_CH < 1 || NUM_CH > SASL_MAX_CH) begin : g_bad_num_ch
        $error("sasl_top: NUM_CH must lie between 1 and 64");
    end

    typedef struct packed {
        sasl_fsm_e                  fsm;
        logic                       en;
        logic                       setup;
        logic                       idle;
        logic [SASL_ERR_W-1:0]      err;
        logic [NUM_CH-1:0]          unlocked;
        logic [NUM_CH-1:0][31:0]    remap;
        logic [SASL_SEL_W-1:0]      cur;
        sasl_mst_req_s              mreq;
        logic                       ack;
        logic                       aerr;
        logic [31:0]                ardata;
        logic [31:0]                rdata;
    } sasl_state_s;

    sasl_state_s             q;
    sasl_state_s             d;

    logic [SASL_ADDR_W-1:0]  remap_off;
    logic [SASL_ADDR_W-3:0]  remap_idx;
    logic                    remap_hit;
    logic [SASL_SEL_W-1:0]   unl_ch;
    logic [7:0]              unl_key;
    logic                    unlock_wr;
    logic                    clear_wr;
    logic                    take_ok;
    logic [SASL_ERR_W-1:0]   err_set;
    logic [SASL_ERR_W-1:0]   err_clr;
    logic [NUM_CH-1:0]       unl_set;
    logic [NUM_CH-1:0]       unl_clr;
    logic [31:0]             status;

    // decode helpers shared by the next-state logic and the checks
    always_comb begin
        remap_off = reg_addr - SASL_OFF_REMAP;
        remap_idx = remap_off[SASL_ADDR_W-1:2];
        remap_hit = (reg_addr >= SASL_OFF_REMAP)
                    && (remap_off[1:0] == 2'h0)
                    && (32'(remap_idx) < 32'(NUM_CH));
        unl_ch    = reg_wdata[SASL_SEL_W-1:0];
        unl_key   = reg_wdata[SASL_KEY_LSB +: 8];
        unlock_wr = reg_wr && (reg_addr == SASL_OFF_UNLOCK);
        clear_wr  = reg_wr && (reg_addr == SASL_OFF_CLEAR);
        // only an enabled unit outside setup forwards, and only unlocked channels
        take_ok   = q.en && !q.setup
                    && (32'(ch_req.sel) < 32'(NUM_CH))
                    && q.unlocked[ch_req.sel];
        status    = '0;
        status[SASL_ST_IDLE_BIT]  = q.idle;
        status[SASL_ST_SETUP_BIT] = q.setup;
        status[SASL_ST_EN_BIT]    = q.en;
        status[SASL_ST_ERR_LSB +: SASL_ERR_W] = q.err;
    end

    always_comb begin
        d       = q;
        d.ack   = 1'b0;
        d.aerr  = 1'b0;
        d.rdata = '0;
        err_set = '0;
        err_clr = '0;
        unl_set = '0;
        unl_clr = '0;

        // register writes; the status register is read-only, so a write
        // to it simply matches no branch here
        if (reg_wr) begin
            if (reg_addr == SASL_OFF_CTRL) begin
                d.en    = reg_wdata[SASL_CTRL_EN_BIT];
                d.setup = reg_wdata[SASL_CTRL_SETUP_BIT];
            end else if (reg_addr == SASL_OFF_CLEAR) begin
                err_clr = reg_wdata[SASL_ST_ERR_LSB +: SASL_ERR_W];
            end else if (reg_addr == SASL_OFF_UNLOCK) begin
                // blocked test uses the flags as they stood before this write
                if (|q.err) begin
                    err_set[SASL_E_UNL_BLOCK] = 1'b1;
                end else if (unl_key != SASL_UNLOCK_KEY) begin
                    err_set[SASL_E_UNL_KEY] = 1'b1;
                end else if (32'(unl_ch) < 32'(NUM_CH)) begin
                    unl_set[unl_ch] = 1'b1;
                end
            end else if (remap_hit && q.setup) begin
                // targets only change in the configuration phase
                d.remap[remap_idx] = reg_wdata;
                if (reg_wdata[31:16] < SASL_REMAP_MIN) begin
                    err_set[SASL_E_REMAP] = 1'b1;
                end
            end
        end

        // register reads, data stand in the following cycle only
        if (reg_rd) begin
            if (reg_addr == SASL_OFF_STATUS) begin
                d.rdata = status;
            end else if (reg_addr == SASL_OFF_CTRL) begin
                d.rdata[SASL_CTRL_EN_BIT]    = q.en;
                d.rdata[SASL_CTRL_SETUP_BIT] = q.setup;
            end else if (reg_addr == SASL_OFF_UNLOCK) begin
                // reads zero; the key must never be observable
                err_set[SASL_E_UNL_READ] = 1'b1;
            end else if (remap_hit) begin
                d.rdata = q.remap[remap_idx];
            end
        end

        // channel engine
        case (q.fsm)
            SASL_S_IDLE: begin
                if (ch_req.valid) begin
                    if (take_ok) begin
                        d.idle       = 1'b0;
                        d.cur        = ch_req.sel;
                        d.mreq.valid = 1'b1;
                        d.mreq.write = ch_req.write;
                        d.mreq.addr  = q.remap[ch_req.sel];
                        d.mreq.wdata = ch_req.wdata;
                        d.fsm        = SASL_S_ISSUE;
                    end else begin
                        // refused at once, nothing goes to the master side
                        d.ack  = 1'b1;
                        d.aerr = 1'b1;
                    end
                end
            end
            SASL_S_ISSUE: begin
                if (m_ready) begin
                    d.mreq.valid = 1'b0;
                    d.fsm        = SASL_S_WAIT;
                end
            end
            SASL_S_WAIT: begin
                if (m_rsp.valid) begin
                    if (m_rsp.err) begin
                        err_set[SASL_E_MBERR] = 1'b1;
                    end
                    d.ack      = 1'b1;
                    d.aerr     = m_rsp.err;
                    d.ardata   = m_rsp.rdata;
                    // one access per unlock: the channel locks again
                    unl_clr[q.cur] = 1'b1;
                    d.fsm      = SASL_S_DONE;
                end
            end
            SASL_S_DONE: begin
                // response taken, no transfer left on the master side
                d.idle = 1'b1;
                d.fsm  = SASL_S_IDLE;
            end
            default: begin
                d.fsm  = SASL_S_IDLE;
                d.idle = 1'b1;
            end
        endcase

        // a fresh unlock wins over the relock of a finished access
        d.unlocked = (q.unlocked & ~unl_clr) | unl_set;
        // set wins over clear, so no event is lost in the clearing cycle
        d.err      = (q.err & ~err_clr) | err_set;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q      <= '0;
            q.idle <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    assign reg_rdata       = q.rdata;
    assign ch_ready        = q.idle;
    assign ch_ack          = q.ack;
    assign ch_err          = q.aerr;
    assign ch_rdata        = q.ardata;
    assign m_req           = q.mreq;
    assign enabled         = q.en;
    assign setup_mode_flag = q.setup;

    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_idle_drop_on_start: assert property (
        (ce && q.fsm == SASL_S_IDLE && ch_req.valid && take_ok)
        |=> (!q.idle && q.fsm == SASL_S_ISSUE && q.mreq.valid))
        else $error("idle did not drop when a channel access started");

    a_idle_low_while_busy: assert property (
        (q.fsm != SASL_S_IDLE) |-> !q.idle)
        else $error("idle high while an access is outstanding");

    a_idle_rise_after_resp: assert property (
        (ce && q.fsm == SASL_S_WAIT && m_rsp.valid)
        ##1 ce |=> (q.idle && q.fsm == SASL_S_IDLE))
        else $error("idle did not return after the response");

    a_setup_flag_follow: assert property (
        (ce && reg_wr && reg_addr == SASL_OFF_CTRL)
        |=> (q.setup == $past(reg_wdata[SASL_CTRL_SETUP_BIT])
             && status[SASL_ST_SETUP_BIT] == q.setup))
        else $error("setup flag does not follow the control write");

    a_en_flag_follow: assert property (
        (ce && reg_wr && reg_addr == SASL_OFF_CTRL)
        |=> (q.en == $past(reg_wdata[SASL_CTRL_EN_BIT])
             && status[SASL_ST_EN_BIT] == q.en))
        else $error("enabled flag does not follow the control write");

    a_remap_addr_error: assert property (
        (ce && reg_wr && remap_hit && q.setup
         && reg_wdata[31:16] < SASL_REMAP_MIN)
        |=> q.err[SASL_E_REMAP])
        else $error("illegal remap target not flagged");

    a_remap_addr_legal: assert property (
        (ce && !q.err[SASL_E_REMAP] && !(reg_wr && remap_hit && q.setup
         && reg_wdata[31:16] < SASL_REMAP_MIN))
        |=> !q.err[SASL_E_REMAP])
        else $error("remap target error set without cause");

    a_master_bus_error: assert property (
        (ce && q.fsm == SASL_S_WAIT && m_rsp.valid && m_rsp.err)
        |=> (q.err[SASL_E_MBERR] && ch_ack && ch_err))
        else $error("master error response not flagged");

    a_unlock_blocked: assert property (
        (ce && unlock_wr && (|q.err))
        |=> q.err[SASL_E_UNL_BLOCK])
        else $error("blocked unlock not flagged");

    a_unlock_abandoned: assert property (
        (ce && unlock_wr && (|q.err))
        |=> ((q.unlocked & ~$past(q.unlocked)) == '0))
        else $error("channel unlocked while an error flag was set");

    a_unlock_key_error: assert property (
        (ce && unlock_wr && !(|q.err) && unl_key != SASL_UNLOCK_KEY)
        |=> (q.err[SASL_E_UNL_KEY] && (q.unlocked & ~$past(q.unlocked)) == '0))
        else $error("wrong unlock key not flagged");

    a_unlock_read_error: assert property (
        (ce && reg_rd && reg_addr == SASL_OFF_UNLOCK)
        |=> (q.err[SASL_E_UNL_READ] && reg_rdata == 32'h0000_0000))
        else $error("unlock register read not flagged");

    a_err_flags_sticky: assert property (
        (ce && !clear_wr)
        |=> ((q.err & $past(q.err)) == $past(q.err)))
        else $error("error flag dropped without a clear write");

    a_err_clear_one: assert property (
        (ce && clear_wr && !reg_rd && !unlock_wr && !(reg_wr && remap_hit)
         && q.fsm != SASL_S_WAIT)
        |=> (q.err == ($past(q.err)
             & ~$past(reg_wdata[SASL_ST_ERR_LSB +: SASL_ERR_W]))))
        else $error("clear write did not clear exactly its bits");

    a_status_reserved: assert property (
        (ce && reg_rd && reg_addr == SASL_OFF_STATUS)
        |=> (reg_rdata[31:11] == 21'h0 && reg_rdata[2:0] == 3'h0))
        else $error("reserved status bits read nonzero");

    a_status_write_inert: assert property (
        (ce && reg_wr && reg_addr == SASL_OFF_STATUS && q.fsm == SASL_S_IDLE
         && !ch_req.valid)
        |=> (q.err == $past(q.err) && q.en == $past(q.en)
             && q.setup == $past(q.setup) && q.unlocked == $past(q.unlocked)))
        else $error("write to the status register changed state");

    a_refused_no_master: assert property (
        (ce && q.fsm == SASL_S_IDLE && ch_req.valid && !take_ok)
        |=> (ch_ack && ch_err && !q.mreq.valid && q.fsm == SASL_S_IDLE))
        else $error("refused channel request reached the master side");

    a_master_req_held: assert property (
        (q.fsm == SASL_S_ISSUE && !(ce && m_ready))
        |=> (q.mreq.valid && $stable(q.mreq)))
        else $error("master request dropped before it was accepted");

    a_unlock_granted: assert property (
        (ce && unlock_wr && !(|q.err) && unl_key == SASL_UNLOCK_KEY
         && 32'(unl_ch) < 32'(NUM_CH))
        |=> (q.unlocked[$past(unl_ch)] && !q.err[SASL_E_UNL_KEY]))
        else $error("unlock with the right key did not open the channel");

    // a low enable must freeze flags and engine alike
    a_ce_freezes_state: assert property (
        !ce |=> (q == $past(q)))
        else $error("state changed while the clock enable was low");

endmodule

// *** sasl_slave_model.sv ***
// sasl_slave_model: behavioural system bus slave behind the master side.
// assumes a request held until ready and one answer per accepted request.
`timescale 1ns/10ps

module sasl_slave_model
    import sasl_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire sasl_pkg::sasl_mst_req_s m_req,
    input  wire logic [3:0]              delay,
    input  wire logic                    err_en,
    output logic                         m_ready,
    output sasl_pkg::sasl_mst_rsp_s      m_rsp
);
    logic [3:0]  cnt;
    logic        busy;
    logic [31:0] addr_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt     <= 4'h0;
            busy    <= 1'b0;
            addr_q  <= 32'h0;
            m_ready <= 1'b0;
            m_rsp   <= '0;
        end else begin
            m_ready     <= 1'b0;
            m_rsp.valid <= 1'b0;
            m_rsp.err   <= 1'b0;
            // idle data toggles, so a stale word never passes for an answer
            m_rsp.rdata <= ~m_rsp.rdata;
            if (!busy && m_req.valid && !m_ready) begin
                if (cnt == delay) begin
                    m_ready <= 1'b1;
                    cnt     <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
            if (m_ready && m_req.valid) begin
                busy   <= 1'b1;
                addr_q <= m_req.addr;
            end
            // answer never in the accept cycle, at the earliest two cycles after
            if (busy) begin
                if (cnt == delay) begin
                    busy        <= 1'b0;
                    cnt         <= 4'h0;
                    m_rsp.valid <= 1'b1;
                    m_rsp.err   <= err_en;
                    m_rsp.rdata <= addr_q ^ 32'h3c3c_c3c3;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule

// *** sasl_tb_top.sv ***
// sasl_tb_top: self-checking bench for the secure access status logic.
// assumes sasl_top with its default channel count and the slave model.
`timescale 1ns/10ps

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module sasl_tb_top;
    import sasl_pkg::*;
    logic                    clk = 1'b0;
    logic                    nrst = 1'b0;
    logic                    ce = 1'b1;
    logic [SASL_ADDR_W-1:0]  reg_addr = '0;
    logic [31:0]             reg_wdata = '0;
    logic                    reg_wr = 1'b0;
    logic                    reg_rd = 1'b0;
    logic [31:0]             reg_rdata;
    sasl_ch_req_s            ch_req = '0;
    logic                    ch_ready, ch_ack, ch_err, enabled, setup_mode_flag;
    logic [31:0]             ch_rdata, rv;
    sasl_mst_req_s           m_req;
    logic                    m_ready;
    sasl_mst_rsp_s           m_rsp;
    logic [3:0]              pt_delay = 4'h0;
    logic                    pt_err = 1'b0;
    int                      mismatches = 0;
    int                      cmp_count = 0;
    int                      cyc = 0;
    logic [15:0]             ups [6] = '{16'h0000, 16'hfffb, 16'hfffc,
                                         16'hfffd, 16'hfffe, 16'hffff};

    always #5 clk = ~clk;

    sasl_top dut (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ch_req(ch_req), .ch_ready(ch_ready), .ch_ack(ch_ack), .ch_err(ch_err),
        .ch_rdata(ch_rdata), .m_req(m_req), .m_ready(m_ready), .m_rsp(m_rsp),
        .enabled(enabled), .setup_mode_flag(setup_mode_flag));

    sasl_slave_model slave (.clk(clk), .nrst(nrst), .m_req(m_req), .delay(pt_delay),
        .err_en(pt_err), .m_ready(m_ready), .m_rsp(m_rsp));

    task automatic end_of_test();
        $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic chk_st(input logic [31:0] e);
        rd(SASL_OFF_STATUS, rv);
        `CHK(rv, e)
    endtask

    // refused requests must not reach the master side at all
    task automatic acc(input logic w, input logic [5:0] s, input logic [31:0] wd,
                       input logic refuse, input logic berr, input logic [31:0] a);
        int   n;
        logic seen;
        n = 0;
        seen = 1'b0;
        @(posedge clk);
        ch_req <= '{valid: 1'b1, write: w, sel: s, wdata: wd};
        @(posedge clk);
        ch_req.valid <= 1'b0;
        #1;
        while (ch_ack !== 1'b1 && n < 50) begin
            if (!refuse) `CHK(ch_ready, 1'b0)
            if (m_req.valid === 1'b1 && m_ready === 1'b1) begin
                seen = 1'b1;
                `CHK(m_req.addr, a)
                `CHK(m_req.write, w)
                if (w) `CHK(m_req.wdata, wd)
            end
            @(posedge clk);
            #1 n++;
        end
        `CHK(ch_ack, 1'b1)
        `CHK(ch_err, refuse | berr)
        `CHK(seen, !refuse)
        if (!refuse && !w) `CHK(ch_rdata, a ^ 32'h3c3c_c3c3)
        @(posedge clk);
        #1 `CHK(ch_ready, 1'b1)
    endtask

    task automatic t_reset_ro();
        `CHK(ch_ready, 1'b1)
        `CHK({ch_ack, ch_err, enabled, setup_mode_flag, m_req.valid}, 5'h00)
        chk_st(32'h0000_0400);
        wr(SASL_OFF_STATUS, 32'hffff_ffff);
        chk_st(32'h0000_0400);
        rd(12'h0fc, rv);
        `CHK(rv, 32'h0)
    endtask

    task automatic t_setup();
        wr(SASL_OFF_CTRL, 32'h3);
        chk_st(32'h0000_0700);
        `CHK({enabled, setup_mode_flag}, 2'b11)
        acc(1'b0, 6'd2, 32'h0, 1'b1, 1'b0, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(SASL_OFF_REMAP + 12'(4 * i), {ups[i], 16'(4 * i)});
            chk_st(ups[i] < 16'hfffc ? 32'h0000_0780 : 32'h0000_0700);
            wr(SASL_OFF_CLEAR, 32'h80);
        end
        chk_st(32'h0000_0700);
        wr(SASL_OFF_CTRL, 32'h1);
        chk_st(32'h0000_0500);
        wr(SASL_OFF_REMAP, 32'h1234_0000);
        chk_st(32'h0000_0500);
        // illegal targets are kept, writes outside setup are dropped
        rd(SASL_OFF_REMAP + 12'h004, rv);
        `CHK(rv, 32'hfffb_0004)
        rd(SASL_OFF_REMAP, rv);
        `CHK(rv, 32'h0000_0000)
        rd(SASL_OFF_CTRL, rv);
        `CHK(rv, 32'h0000_0001)
    endtask

    task automatic t_unlock_err();
        rd(SASL_OFF_UNLOCK, rv);
        chk_st(32'h0000_0508);
        wr(SASL_OFF_UNLOCK, 32'ha500_0002);
        chk_st(32'h0000_0528);
        acc(1'b0, 6'd2, 32'h0, 1'b1, 1'b0, 32'h0);
        wr(SASL_OFF_CLEAR, 32'h08);
        chk_st(32'h0000_0520);
        wr(SASL_OFF_CLEAR, 32'h20);
        wr(SASL_OFF_UNLOCK, 32'h5a00_0002);
        chk_st(32'h0000_0510);
        acc(1'b0, 6'd2, 32'h0, 1'b1, 1'b0, 32'h0);
        wr(SASL_OFF_CLEAR, 32'h10);
        chk_st(32'h0000_0500);
    endtask

    task automatic t_access();
        pt_delay <= 4'h3;
        wr(SASL_OFF_UNLOCK, 32'ha500_0002);
        acc(1'b0, 6'd2, 32'h0, 1'b0, 1'b0, 32'hfffc_0008);
        acc(1'b0, 6'd2, 32'h0, 1'b1, 1'b0, 32'h0);
        pt_delay <= 4'h0;
        pt_err <= 1'b1;
        wr(SASL_OFF_UNLOCK, 32'ha500_0003);
        acc(1'b1, 6'd3, 32'hdead_beef, 1'b0, 1'b1, 32'hfffd_000c);
        chk_st(32'h0000_0540);
        wr(SASL_OFF_UNLOCK, 32'ha500_0003);
        chk_st(32'h0000_0560);
        wr(SASL_OFF_CLEAR, 32'h60);
        chk_st(32'h0000_0500);
        wr(SASL_OFF_CTRL, 32'h0);
        chk_st(32'h0000_0400);
        `CHK(enabled, 1'b0)
    endtask

    // a control write with the clock enable low must leave the unit disabled
    task automatic t_freeze();
        ce <= 1'b0;
        wr(SASL_OFF_CTRL, 32'h3);
        ce <= 1'b1;
        chk_st(32'h0000_0400);
        `CHK({enabled, setup_mode_flag}, 2'b00)
    endtask

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        t_reset_ro();
        t_setup();
        t_unlock_err();
        t_access();
        t_freeze();
        end_of_test();
    end
endmodule
